// ===== verilog/xfer_decode_pkg.sv
// Purpose: Shared constants and types for the data-transfer decoder
// Assumes: One opcode byte, then a mode/register/rm byte where needed
// Notes: Clock figures are least execution clocks per instruction
package xfer_decode_pkg;
    // Opcode bytes of the decoded group
    localparam logic [7:0] OPC_SEG_LOAD = 8'h8e;
    localparam logic [7:0] OPC_SEG_STORE = 8'h8c;
    localparam logic [7:0] OPC_EFF_OFS = 8'h8d;
    localparam logic [7:0] OPC_FAR_DS = 8'hc5;
    localparam logic [7:0] OPC_FAR_ES = 8'hc4;
    localparam logic [7:0] OPC_TABLE = 8'hd7;
    localparam logic [7:0] OPC_FL_TO_AH = 8'h9f;
    localparam logic [7:0] OPC_AH_TO_FL = 8'h9e;
    // General move family 1000_10dw
    localparam logic [6:0] OPC_MOV_TO_RM = 7'h44;
    localparam logic [6:0] OPC_MOV_TO_REG = 7'h45;
    // Mode field value that names a register operand
    localparam logic [1:0] MOD_REG = 2'h3;
    // Field positions
    localparam int MOD_HI = 7;
    localparam int MOD_LO = 6;
    localparam int W_BIT = 0;
    // Count widths
    localparam int CW = 5;
    localparam int UW = 8;
    // Least clocks, register form / memory form
    localparam logic [CW-1:0] CLK_SEG_LOAD_R = 5'h02;
    localparam logic [CW-1:0] CLK_SEG_LOAD_M = 5'h09;
    localparam logic [CW-1:0] CLK_SEG_STORE_R = 5'h02;
    localparam logic [CW-1:0] CLK_SEG_STORE_M = 5'h0b;
    localparam logic [CW-1:0] CLK_EFF_OFS = 5'h06;
    localparam logic [CW-1:0] CLK_FAR_PTR = 5'h12;
    localparam logic [CW-1:0] CLK_TABLE = 5'h0b;
    localparam logic [CW-1:0] CLK_FL_TO_AH = 5'h02;
    localparam logic [CW-1:0] CLK_AH_TO_FL = 5'h03;
    localparam logic [CW-1:0] CLK_MOV_TO_RM_M = 5'h0c;
    localparam logic [CW-1:0] CLK_MOV_TO_REG_M = 5'h09;
    localparam logic [CW-1:0] CLK_MOV_R = 5'h02;
    // Extra clocks: handshake ceiling, one extra word bus cycle
    localparam logic [1:0] HS_MAX = 2'h2;
    localparam logic [CW-1:0] ODD_EXTRA = 5'h04;
    localparam logic [UW-1:0] USED_ONE = 8'h01;
    // Operation kinds
    typedef enum logic [3:0] {
        OP_NONE, OP_SEG_LOAD, OP_SEG_STORE, OP_EFF_OFS, OP_FAR_DS,
        OP_FAR_ES, OP_TABLE, OP_FL_TO_AH, OP_AH_TO_FL, OP_MOV_TO_RM,
        OP_MOV_TO_REG
    } op_t;
    // Decoder states
    typedef enum logic [1:0] {ST_OPC, ST_MODRM, ST_EXEC} st_t;
endpackage

// ===== verilog/data_transfer_instr_decode.sv
// Purpose: Decode data-transfer opcodes and time their execution
// Assumes: Bytes arrive from the bus_fetch_unit queue on a valid/ready pair
// Notes: Counts start from the listed figure and grow with bus extras
`timescale 1ns/1ps
module data_transfer_instr_decode
    import xfer_decode_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Byte stream from the bus_fetch_unit queue
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic byte_ready_r,
    // Bus conditions during execution
    input wire logic bus_wait,
    input wire logic bus_hold,
    input wire logic [1:0] hs_extra,
    input wire logic odd_word_addr,
    input wire logic bus16_mode,
    // Decode result
    output op_t op_kind_r,
    output logic word_op_r,
    output logic mem_op_r,
    output logic illegal_r,
    output logic [CW-1:0] min_clocks_r,
    output logic [UW-1:0] used_clocks_r,
    output logic busy_r,
    output logic done_r
);

    // Map an opcode byte to its kind
    function automatic op_t kind_of(input logic [7:0] b);
        op_t k;
        k = OP_NONE;
        case (b)
            OPC_SEG_LOAD: k = OP_SEG_LOAD;
            OPC_SEG_STORE: k = OP_SEG_STORE;
            OPC_EFF_OFS: k = OP_EFF_OFS;
            OPC_FAR_DS: k = OP_FAR_DS;
            OPC_FAR_ES: k = OP_FAR_ES;
            OPC_TABLE: k = OP_TABLE;
            OPC_FL_TO_AH: k = OP_FL_TO_AH;
            OPC_AH_TO_FL: k = OP_AH_TO_FL;
            default: begin
                if (b[7:1] == OPC_MOV_TO_RM) begin
                    k = OP_MOV_TO_RM;
                end else if (b[7:1] == OPC_MOV_TO_REG) begin
                    k = OP_MOV_TO_REG;
                end
            end
        endcase
        return k;
    endfunction

    // Whether the kind takes a mode/register/rm byte
    function automatic logic has_modrm(input op_t k);
        logic m;
        m = 1'b1;
        case (k)
            OP_TABLE, OP_FL_TO_AH, OP_AH_TO_FL, OP_NONE: m = 1'b0;
            default: m = 1'b1;
        endcase
        return m;
    endfunction

    // Least clocks; is_reg picks the first figure of a pair
    function automatic logic [CW-1:0] min_clk(input op_t k, input logic is_reg);
        logic [CW-1:0] c;
        c = CLK_MOV_R;
        case (k)
            // Pair figures, register first then memory
            OP_SEG_LOAD: c = is_reg ? CLK_SEG_LOAD_R : CLK_SEG_LOAD_M;
            OP_SEG_STORE: c = is_reg ? CLK_SEG_STORE_R : CLK_SEG_STORE_M;
            OP_EFF_OFS: c = CLK_EFF_OFS;
            OP_FAR_DS: c = CLK_FAR_PTR;
            OP_FAR_ES: c = CLK_FAR_PTR;
            OP_TABLE: c = CLK_TABLE;
            OP_FL_TO_AH: c = CLK_FL_TO_AH;
            OP_AH_TO_FL: c = CLK_AH_TO_FL;
            OP_MOV_TO_RM: c = is_reg ? CLK_MOV_R : CLK_MOV_TO_RM_M;
            OP_MOV_TO_REG: c = is_reg ? CLK_MOV_R : CLK_MOV_TO_REG_M;
            default: c = CLK_MOV_R;
        endcase
        return c;
    endfunction

    // State and working registers
    st_t state_r; // Decoder state
    st_t state_nxt;
    logic [CW-1:0] remain_r; // Clocks left in execution
    logic [CW-1:0] remain_nxt;
    logic [7:0] opc_r; // Held opcode byte
    op_t kind_r; // Held kind while the second byte waits

    // Byte handshake and decode wires
    wire take = byte_valid & byte_ready_r;
    wire op_t k_new = kind_of(byte_data);
    wire is_reg = (byte_data[MOD_HI:MOD_LO] == MOD_REG);
    wire no_reg_form = (kind_r == OP_FAR_DS) || (kind_r == OP_FAR_ES);
    wire bad_modrm = no_reg_form & is_reg;
    wire stall = bus_wait | bus_hold;
    wire last = (state_r == ST_EXEC) && (remain_r == 5'h01) && !stall;

    // Width: fixed word for segment and pointer work, w bit for moves
    wire w_new = (kind_r == OP_MOV_TO_RM || kind_r == OP_MOV_TO_REG) ?
                 opc_r[W_BIT] : 1'b1;

    // Memory form and the extra clocks that it may carry
    wire op_t k_ld = (state_r == ST_OPC) ? k_new : kind_r;
    wire mem_ld = (state_r == ST_OPC) ? (k_new == OP_TABLE) :
                  (!is_reg && kind_r != OP_EFF_OFS);
    wire w_ld = (state_r == ST_OPC) ? 1'b0 : w_new;
    wire [1:0] hs_cl = (hs_extra > HS_MAX) ? HS_MAX : hs_extra;
    wire [CW-1:0] hs_add = mem_ld ? {3'h0, hs_cl} : 5'h00;
    wire odd_hit = mem_ld & w_ld & odd_word_addr & bus16_mode;
    wire [CW-1:0] odd_add = odd_hit ? ODD_EXTRA : 5'h00;
    wire [CW-1:0] base_ld = min_clk(k_ld, (state_r == ST_OPC) | is_reg);
    // A count never shrinks below its listed figure
    wire [CW-1:0] count_ld = base_ld + hs_add + odd_add;
    // Load events: single-byte opcode, or a good second byte
    wire ld_single = take && (state_r == ST_OPC) && (k_new != OP_NONE) &&
                     !has_modrm(k_new);
    wire ld_modrm = take && (state_r == ST_MODRM) && !bad_modrm;
    wire ld_exec = ld_single | ld_modrm;
    wire bad_opc = take && (state_r == ST_OPC) && (k_new == OP_NONE);
    wire bad_any = bad_opc | (take && (state_r == ST_MODRM) && bad_modrm);

    // Next state; byte wait in MODRM is counted as lost time
    always_comb begin
        state_nxt = state_r;
        remain_nxt = remain_r;
        case (state_r)
            ST_OPC: begin
                if (take && has_modrm(k_new)) begin
                    state_nxt = ST_MODRM;
                end else if (ld_single) begin
                    state_nxt = ST_EXEC;
                    remain_nxt = count_ld;
                end
            end
            ST_MODRM: begin
                if (ld_modrm) begin
                    state_nxt = ST_EXEC;
                    remain_nxt = count_ld;
                end else if (take) begin
                    // Register form refused: drop back to opcode fetch
                    state_nxt = ST_OPC;
                end
            end
            ST_EXEC: begin
                // Hold the count while the bus stalls
                if (last) begin
                    state_nxt = ST_OPC;
                    remain_nxt = 5'h00;
                end else if (!stall) begin
                    remain_nxt = remain_r - 5'h01;
                end
            end
            default: begin
                state_nxt = ST_OPC;
                remain_nxt = 5'h00;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_OPC;
            remain_r <= 5'h00;
        end else begin
            state_r <= state_nxt;
            remain_r <= remain_nxt;
        end
    end

    // Held opcode and kind
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            opc_r <= 8'h00;
            kind_r <= OP_NONE;
        end else if (take && state_r == ST_OPC) begin
            opc_r <= byte_data;
            kind_r <= k_new;
        end
    end

    // Handshake and status outputs
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            byte_ready_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            byte_ready_r <= (state_nxt != ST_EXEC);
            busy_r <= (state_nxt != ST_OPC);
            done_r <= last;
            illegal_r <= bad_any;
        end
    end

    // Decode result, captured when execution starts
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            op_kind_r <= OP_NONE;
            word_op_r <= 1'b0;
            mem_op_r <= 1'b0;
            min_clocks_r <= 5'h00;
        end else if (ld_exec) begin
            op_kind_r <= k_ld;
            word_op_r <= w_ld;
            mem_op_r <= mem_ld;
            // Figures already cover any target fetch; none here branch
            min_clocks_r <= base_ld;
        end
    end

    // Clocks spent from opcode taken to completion, waits included
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            used_clocks_r <= 8'h00;
        end else if (take && state_r == ST_OPC) begin
            used_clocks_r <= USED_ONE;
        end else if (busy_r && !done_r) begin
            used_clocks_r <= used_clocks_r + USED_ONE;
        end
    end

    // Completion never comes before the listed figure
    a_least_clocks: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done_r |-> (used_clocks_r >= {3'h0, min_clocks_r}))
        else $error("finished before least count");
    a_stall_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state_r == ST_EXEC && stall) |=> $stable(remain_r))
        else $error("count moved during stall");
    a_far_no_reg: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (take && state_r == ST_MODRM && no_reg_form && is_reg) |=>
        (illegal_r && state_r == ST_OPC))
        else $error("register far pointer not refused");
    a_table_count: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_single && k_new == OP_TABLE) |=> (min_clocks_r == CLK_TABLE))
        else $error("table lookup count wrong");
    // Three unstalled counting edges, then done is seen one edge later
    a_ah_fl_time: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_single && k_new == OP_AH_TO_FL) ##1
        (!bus_wait && !bus_hold)[*3] |=> done_r)
        else $error("flags store not done in three");
    a_fl_ah_time: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_single && k_new == OP_FL_TO_AH) ##1 (!stall)[*2] |=> done_r)
        else $error("flags load not done in two");
    // Pair figure follows the mode field of the second byte
    a_seg_pair: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_modrm && kind_r == OP_SEG_LOAD) |=>
        (min_clocks_r == ($past(is_reg) ? CLK_SEG_LOAD_R : CLK_SEG_LOAD_M)))
        else $error("segment load count wrong");
    a_seg_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_modrm && kind_r == OP_SEG_STORE) |=>
        (min_clocks_r == ($past(is_reg) ? CLK_SEG_STORE_R : CLK_SEG_STORE_M)))
        else $error("segment store count wrong");
    a_width_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_modrm && kind_r == OP_MOV_TO_REG) |=> (word_op_r == $past(opc_r[W_BIT])))
        else $error("width bit ignored");
    a_eff_ofs: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_modrm && kind_r == OP_EFF_OFS) |=> (min_clocks_r == CLK_EFF_OFS && !mem_op_r))
        else $error("effective offset count wrong");

    // No bytes are taken while an instruction is counting down
    a_ready_exec: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state_r == ST_EXEC) |-> !byte_ready_r)
        else $error("byte accepted during execution");
    // Forms without memory access carry no extra clocks
    a_no_extra: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_exec && !mem_ld) |=> (remain_r == min_clocks_r))
        else $error("extra clocks on register form");
    // Handshake extras never exceed two clocks
    a_hs_ceiling: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_exec && mem_ld && !odd_hit) |=> (remain_r <= min_clocks_r + {3'h0, HS_MAX}))
        else $error("handshake extra above ceiling");
    // An odd word on the wide bus costs one more bus cycle
    a_odd_extra: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ld_exec && odd_hit) |=> (remain_r >= min_clocks_r + ODD_EXTRA))
        else $error("odd word extra missing");
    // Completion is a single-cycle pulse
    a_done_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
        done_r |=> !done_r)
        else $error("done held longer than one cycle");

endmodule

// ===== dv/fetch_queue_model.sv
// Purpose: Behavioural prefetch queue that feeds instruction bytes to the decoder
// Assumes: The bench loads one instruction of one or two bytes at a time
// Notes: gap puts idle cycles before each byte to model a slow queue
`timescale 1ns/1ps
module fetch_queue_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Instruction to deliver
    input wire logic load,
    input wire logic [7:0] first_byte,
    input wire logic [7:0] second_byte,
    input wire logic two_bytes,
    input wire logic [3:0] gap,
    // Byte stream to the decoder
    input wire logic byte_ready_r,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    logic [7:0] pend [2]; // Bytes still owed
    int left; // Bytes not yet taken
    int idx; // Next byte to offer
    int idle; // Idle cycles before the next offer
    logic taken; // Byte accepted at the last rising edge

    // Note an accept where the decoder samples it
    always @(posedge clk_sys) begin
        taken = byte_valid && byte_ready_r;
    end

    // Offer just after the falling edge and hold until taken
    always @(negedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            byte_valid <= 1'b0;
            byte_data <= 8'h00;
            left = 0;
            idx = 0;
            idle = 0;
        end else begin
            if (taken) begin
                left = left - 1;
                idx = idx + 1;
                idle = gap;
            end
            if (load) begin
                pend[0] = first_byte;
                pend[1] = second_byte;
                left = two_bytes ? 2 : 1;
                idx = 0;
                idle = gap;
            end
            if (left > 0 && idle == 0) begin
                // Byte already waiting in the queue
                byte_valid <= 1'b1;
                byte_data <= pend[idx];
            end else begin
                // Nothing offered: data toggles so no stale byte is seen
                if (idle > 0) idle = idle - 1;
                byte_valid <= 1'b0;
                byte_data <= ~byte_data;
            end
        end
    end
endmodule

// ===== dv/data_transfer_instr_decode_tb.sv
// Purpose: Self-checking bench for the data-transfer decoder
// Assumes: Inputs change at the falling edge
// Notes: Execution time is measured from the last byte accepted to done
`timescale 1ns/1ps
module data_transfer_instr_decode_tb
    import xfer_decode_pkg::*;
;
    logic clk_sys = 1'b0; // 25 MHz clock
    logic rst_b = 1'b0; // Active-low reset
    logic load = 1'b0; // Queue load strobe
    logic [7:0] b0 = 8'h00; // Opcode byte
    logic [7:0] b1 = 8'h00; // Mode byte
    logic two = 1'b0; // Two-byte instruction
    logic [3:0] gap = 4'h0; // Queue idle cycles
    logic bus_wait = 1'b0; // Wait state
    logic bus_hold = 1'b0; // Hold request
    logic [1:0] hs_extra = 2'h0; // Handshake extra clocks
    logic odd_word_addr = 1'b0; // Odd word operand
    logic bus16_mode = 1'b0; // 16-bit bus variant
    logic byte_valid, byte_ready_r, word_op_r, mem_op_r, illegal_r, busy_r, done_r;
    logic [7:0] byte_data, used_clocks_r;
    logic [CW-1:0] min_clocks_r;
    op_t op_kind_r;
    int cyc = 0, acc_cyc = 0, done_cyc = 0; // Edge count, last accept, last done
    logic done_seen = 1'b0, ill_seen = 1'b0; // Pulses caught since the last start
    int fail_count = 0, checks_done = 0; // Result counters

    // Clock, 40 ns period
    always #20 clk_sys = ~clk_sys;

    data_transfer_instr_decode i_data_transfer_instr_decode (
        .clk_sys(clk_sys), .rst_b(rst_b), .byte_valid(byte_valid), .byte_data(byte_data),
        .byte_ready_r(byte_ready_r), .bus_wait(bus_wait), .bus_hold(bus_hold),
        .hs_extra(hs_extra), .odd_word_addr(odd_word_addr), .bus16_mode(bus16_mode),
        .op_kind_r(op_kind_r), .word_op_r(word_op_r), .mem_op_r(mem_op_r),
        .illegal_r(illegal_r), .min_clocks_r(min_clocks_r), .used_clocks_r(used_clocks_r),
        .busy_r(busy_r), .done_r(done_r));

    fetch_queue_model i_fetch_queue_model (
        .clk_sys(clk_sys), .rst_b(rst_b), .load(load), .first_byte(b0), .second_byte(b1),
        .two_bytes(two), .gap(gap), .byte_ready_r(byte_ready_r), .byte_valid(byte_valid),
        .byte_data(byte_data));

    // Record accepts and pulses with pre-edge values
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (byte_valid && byte_ready_r) acc_cyc <= cyc;
        if (done_r === 1'b1) done_seen <= 1'b1;
        if (done_r === 1'b1) done_cyc <= cyc;
        if (illegal_r === 1'b1) ill_seen <= 1'b1;
    end

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hand one instruction to the queue model
    task automatic start(input logic [7:0] a, input logic [7:0] b, input logic t);
        @(negedge clk_sys);
        done_seen = 1'b0;
        ill_seen = 1'b0;
        b0 <= a;
        b1 <= b;
        two <= t;
        load <= 1'b1;
        @(negedge clk_sys);
        load <= 1'b0;
    endtask

    // Wait for done, then judge the result; mem x means not judged
    task automatic finish(input op_t k, input logic [4:0] m, input logic mem, input logic w,
                          input int n);
        int i;
        i = 0;
        while (done_seen !== 1'b1 && i < 200) begin
            @(negedge clk_sys);
            i++;
        end
        cmp("done", 1, done_seen);
        cmp("kind", k, op_kind_r);
        cmp("least clocks", m, min_clocks_r);
        cmp("clocks to done", n + 1, done_cyc - acc_cyc);
        cmp("idle after done", 0, busy_r);
        cmp("used not below least", 1, used_clocks_r >= {3'h0, min_clocks_r});
        cmp("word", w, word_op_r);
        if (mem !== 1'bx) cmp("memory form", mem, mem_op_r);
        cmp("ready after done", 1, byte_ready_r);
    endtask

    task automatic one(input logic [7:0] a, input logic [7:0] b, input logic t, input op_t k,
                       input logic [4:0] m, input logic mem, input logic w, input int n);
        start(a, b, t);
        finish(k, m, mem, w, n);
    endtask

    task automatic cond(input logic [1:0] h, input logic o, input logic b16);
        @(negedge clk_sys);
        hs_extra <= h;
        odd_word_addr <= o;
        bus16_mode <= b16;
    endtask

    task automatic t_single();
        one(8'h9e, 8'h00, 0, OP_AH_TO_FL, 5'd3, 1'bx, 0, 3);
        one(8'h9f, 8'h00, 0, OP_FL_TO_AH, 5'd2, 1'bx, 0, 2);
        one(8'hd7, 8'h00, 0, OP_TABLE, 5'd11, 1'b1, 0, 11);
        $display("test single done");
    endtask

    task automatic t_pairs();
        one(8'h8e, 8'hc0, 1, OP_SEG_LOAD, 5'd2, 0, 1, 2);
        one(8'h8e, 8'h06, 1, OP_SEG_LOAD, 5'd9, 1, 1, 9);
        one(8'h8c, 8'hd8, 1, OP_SEG_STORE, 5'd2, 0, 1, 2);
        one(8'h8c, 8'h1e, 1, OP_SEG_STORE, 5'd11, 1, 1, 11);
        one(8'h8d, 8'h06, 1, OP_EFF_OFS, 5'd6, 1'bx, 1, 6);
        one(8'hc5, 8'h06, 1, OP_FAR_DS, 5'd18, 1, 1, 18);
        one(8'hc4, 8'h46, 1, OP_FAR_ES, 5'd18, 1, 1, 18);
        one(8'h88, 8'h07, 1, OP_MOV_TO_RM, 5'd12, 1, 0, 12);
        one(8'h8b, 8'hc1, 1, OP_MOV_TO_REG, 5'd2, 0, 1, 2);
        gap <= 4'h3;
        one(8'h8e, 8'h06, 1, OP_SEG_LOAD, 5'd9, 1, 1, 9);
        gap <= 4'h0;
        $display("test pairs done");
    endtask

    task automatic t_extra();
        cond(2'h2, 0, 0);
        one(8'h8e, 8'h06, 1, OP_SEG_LOAD, 5'd9, 1, 1, 11);
        cond(2'h3, 0, 0);
        one(8'h8e, 8'h06, 1, OP_SEG_LOAD, 5'd9, 1, 1, 11);
        cond(2'h0, 1, 1);
        one(8'h8b, 8'h06, 1, OP_MOV_TO_REG, 5'd9, 1, 1, 13);
        one(8'h8a, 8'h06, 1, OP_MOV_TO_REG, 5'd9, 1, 0, 9);
        cond(2'h0, 1, 0);
        one(8'h8b, 8'h06, 1, OP_MOV_TO_REG, 5'd9, 1, 1, 9);
        cond(2'h0, 0, 0);
        $display("test extra done");
    endtask

    // Three wait cycles then two hold cycles from the first execution edge, before any count
    task automatic t_stall();
        int i;
        start(8'hd7, 8'h00, 0);
        for (i = 0; i < 50 && busy_r !== 1'b1; i++) @(negedge clk_sys);
        cmp("busy in exec", 1, busy_r);
        bus_wait <= 1'b1;
        repeat (3) @(negedge clk_sys);
        bus_wait <= 1'b0;
        bus_hold <= 1'b1;
        repeat (2) @(negedge clk_sys);
        bus_hold <= 1'b0;
        finish(OP_TABLE, 5'd11, 1, 0, 16);
        $display("test stall done");
    endtask

    task automatic t_illegal();
        logic [7:0] opc [3] = '{8'hc5, 8'hc4, 8'h00};
        for (int j = 0; j < 3; j++) begin
            start(opc[j], 8'hc0, j < 2);
            repeat (25) @(negedge clk_sys);
            cmp("illegal pulse", 1, ill_seen);
            cmp("no done", 0, done_seen);
            cmp("ready again", 1, byte_ready_r);
        end
        one(8'h9f, 8'h00, 0, OP_FL_TO_AH, 5'd2, 1'bx, 0, 2);
        $display("test illegal done");
    endtask

    // Main sequence
    initial begin
        repeat (20) @(negedge clk_sys);
        cmp("reset kind", OP_NONE, op_kind_r);
        cmp("reset ready", 0, byte_ready_r);
        rst_b <= 1'b1;
        repeat (2) @(negedge clk_sys);
        t_single();
        t_pairs();
        t_extra();
        t_stall();
        t_illegal();
        test_done();
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        test_done();
    end
endmodule
